/* File: efm_pkg.sv */
package efm_pkg;
  // Page and address map of the E1 control page
  localparam logic [3:0] PAGE_CTRL          = 4'h1;
  localparam logic [4:0] ADDR_MODE_SELECT   = 5'h10;
  localparam logic [4:0] ADDR_TX_ALARM      = 5'h11;
  localparam logic [4:0] ADDR_SLOT_ZERO     = 5'h12;
  localparam logic [4:0] ADDR_TX_MF_ALIGN   = 5'h13;
  localparam logic [4:0] ADDR_IRQ_SIG       = 5'h14;
  localparam logic [4:0] ADDR_CODING_LOOP   = 5'h15;
  localparam logic [4:0] ADDR_NON_FRAME     = 5'h16;
  localparam logic [4:0] ADDR_MF_LINK_SEL   = 5'h17;
  localparam logic [4:0] ADDR_TX_MESSAGE    = 5'h18;
  localparam logic [4:0] ADDR_ERROR_INSERT  = 5'h19;
  localparam logic [4:0] ADDR_SIGNAL_CTRL   = 5'h1A;
  localparam logic [4:0] ADDR_IRQ_MASK_0    = 5'h1B;
  localparam logic [4:0] ADDR_IRQ_MASK_1    = 5'h1C;
  localparam logic [4:0] ADDR_IRQ_MASK_2    = 5'h1D;
  localparam logic [4:0] ADDR_IRQ_MASK_3    = 5'h1E;
  localparam logic [4:0] ADDR_LINE_RX       = 5'h1F;
  localparam int         NUM_REGS           = 16;

  // Mode select field positions
  localparam int BIT_AIS_CRITERION_SEL  = 7;
  localparam int BIT_REMAINDER_MODIFY   = 6;
  localparam int BIT_INTERWORKING_DIS   = 5;
  localparam int BIT_REMOTE_ALARM_MAN   = 4;
  localparam int BIT_YBIT_MANUAL        = 3;
  localparam int BIT_CRC4_SYNC_DISABLE  = 2;
  localparam int BIT_BASIC_REFRAME      = 1;
  localparam int BIT_MF_REFRAME         = 0;
  // Other fields the block consumes
  localparam int BIT_TX_TRANSPARENT     = 2;  // slot_zero_ctrl
  localparam int BIT_INTL_NFAS          = 1;  // slot_zero_ctrl
  localparam int BIT_INTL_FAS           = 0;  // slot_zero_ctrl
  localparam int BIT_MANUAL_ALARM       = 5;  // non_frame_align_ctrl
  localparam int BIT_MANUAL_YBIT        = 2;  // tx_multiframe_align

  // Reset values
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // AIS window: one double frame
  localparam int AIS_WINDOW_BITS        = 512;
  localparam int AIS_ZERO_LIMIT         = 3;
  localparam int AIS_CNT_W              = 9;
endpackage : efm_pkg

/* File: efm_ais_if.sv */
// Bit stream into the AIS detector and its verdict back
interface efm_ais_if;
  logic rx_bit;
  logic rx_bit_valid;
  logic criterion_sel;
  logic ais_found;

  modport ctrl (output rx_bit, output rx_bit_valid, output criterion_sel, input ais_found);
  modport det  (input rx_bit, input rx_bit_valid, input criterion_sel, output ais_found);
endinterface : efm_ais_if

/* File: efm_ais_det.sv */
module efm_ais_det (
  input  wire logic clk,
  input  wire logic rst,
  efm_ais_if.det    ais
);
  import efm_pkg::*;

  logic [AIS_CNT_W-1:0] bit_cnt_ff;
  logic [1:0]           zero_cnt_ff;
  logic                 prev_quiet_ff;
  logic                 ais_ff;
  logic                 window_end;
  logic                 quiet_now;
  logic [1:0]           nxt_zero;

  assign window_end = ais.rx_bit_valid && (bit_cnt_ff == AIS_CNT_W'(AIS_WINDOW_BITS - 1));
  // Saturate at the limit: more zeros never matter
  assign nxt_zero   = (!ais.rx_bit && zero_cnt_ff != 2'(AIS_ZERO_LIMIT)) ?
                      zero_cnt_ff + 2'h1 : zero_cnt_ff;
  assign quiet_now  = (nxt_zero < 2'(AIS_ZERO_LIMIT));

  ////////////////////////////////////////////////////////////////////////////
  // Window and zero counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff  <= '0;
      zero_cnt_ff <= 2'h0;
    end else if (ais.rx_bit_valid) begin
      bit_cnt_ff  <= window_end ? '0 : bit_cnt_ff + AIS_CNT_W'(1);
      zero_cnt_ff <= window_end ? 2'h0 : nxt_zero;
    end
  end

  // Verdict updated once per double frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_quiet_ff <= 1'b0;
      ais_ff        <= 1'b0;
    end else if (window_end) begin
      prev_quiet_ff <= quiet_now;
      if (ais.criterion_sel) begin
        ais_ff <= quiet_now && prev_quiet_ff;
      end else begin
        ais_ff <= quiet_now;
      end
    end
  end

  assign ais.ais_found = ais_ff;
endmodule : efm_ais_det

/* File: efm_mode_ctrl.sv */
module efm_mode_ctrl (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Microprocessor port pins
  input  wire logic                 cs_n,
  input  wire logic                 rd_n,
  input  wire logic                 wr_n,
  input  wire logic [3:0]           page_sel,
  input  wire logic [4:0]           addr,
  input  wire logic [7:0]           data_in,
  output logic      [7:0]           data_out,
  output logic                      data_oe,
  // Framer side, same clock
  input  wire logic                 frame_start,
  input  wire logic                 rx_bit,
  input  wire logic                 rx_bit_valid,
  input  wire logic                 basic_sync_ok,
  input  wire logic                 mf_sync_ok,
  input  wire logic [3:0]           serial_tx_input,
  input  wire logic [3:0]           rx_crc_remainder,
  input  wire logic [3:0]           tx_change_crc,
  // Mode results
  output logic                      ais_detect,
  output logic                      interworking_en,
  output logic                      crc4_sync_en,
  output logic                      tx_a_bit,
  output logic                      tx_y_bit,
  output logic                      intl_bit_fas,
  output logic                      intl_bit_nfas,
  output logic                      intl_bits_from_reg,
  output logic [3:0]                tx_crc_bits,
  output logic                      basic_reframe_start,
  output logic                      mf_reframe_start,
  output logic [7:0]                irq_mask_0,
  output logic [7:0]                irq_mask_1,
  output logic [7:0]                irq_mask_2,
  output logic [7:0]                irq_mask_3
);
  import efm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: the port is asynchronous to clk
  logic       cs_n_s1_ff;
  logic       cs_n_s2_ff;
  logic       rd_n_s1_ff;
  logic       rd_n_s2_ff;
  logic       wr_n_s1_ff;
  logic       wr_n_s2_ff;
  logic [3:0] page_s1_ff;
  logic [3:0] page_s2_ff;
  logic [4:0] addr_s1_ff;
  logic [4:0] addr_s2_ff;
  logic [7:0] din_s1_ff;
  logic [7:0] din_s2_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n_s1_ff <= 1'b1;
      cs_n_s2_ff <= 1'b1;
      rd_n_s1_ff <= 1'b1;
      rd_n_s2_ff <= 1'b1;
      wr_n_s1_ff <= 1'b1;
      wr_n_s2_ff <= 1'b1;
      page_s1_ff <= 4'h0;
      page_s2_ff <= 4'h0;
      addr_s1_ff <= 5'h00;
      addr_s2_ff <= 5'h00;
      din_s1_ff  <= 8'h00;
      din_s2_ff  <= 8'h00;
    end else begin
      cs_n_s1_ff <= cs_n;
      cs_n_s2_ff <= cs_n_s1_ff;
      rd_n_s1_ff <= rd_n;
      rd_n_s2_ff <= rd_n_s1_ff;
      wr_n_s1_ff <= wr_n;
      wr_n_s2_ff <= wr_n_s1_ff;
      page_s1_ff <= page_sel;
      page_s2_ff <= page_s1_ff;
      addr_s1_ff <= addr;
      addr_s2_ff <= addr_s1_ff;
      din_s1_ff  <= data_in;
      din_s2_ff  <= data_in_hold(din_s1_ff);
    end
  end

  // Identity helper keeps the second stage a plain register
  function automatic logic [7:0] data_in_hold(input logic [7:0] d);
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: four low lines select one of sixteen words
  function automatic logic hits_page(input logic [3:0] pg, input logic [4:0] a);
    return (pg == PAGE_CTRL) && a[4];
  endfunction

  function automatic logic [3:0] reg_index(input logic [4:0] a);
    return a[3:0];
  endfunction

  logic       wr_active;
  logic       wr_active_ff;
  logic [4:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic [3:0] wr_page_ff;
  logic       wr_commit;
  logic       rd_active;

  assign wr_active = !cs_n_s2_ff && !wr_n_s2_ff;
  assign rd_active = !cs_n_s2_ff && !rd_n_s2_ff && wr_n_s2_ff;
  // Commit at the end of the strobe, when data has surely settled
  assign wr_commit = wr_active_ff && !wr_active;

  // Capture address and data while the write strobe is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_active_ff <= 1'b0;
      wr_addr_ff   <= 5'h00;
      wr_data_ff   <= 8'h00;
      wr_page_ff   <= 4'h0;
    end else begin
      wr_active_ff <= wr_active;
      if (wr_active) begin
        wr_addr_ff <= addr_s2_ff;
        wr_data_ff <= din_s2_ff;
        wr_page_ff <= page_s2_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file of the control page
  logic [7:0] regs_ff [NUM_REGS];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= REG_RESET;
      end
    end else if (wr_commit && hits_page(wr_page_ff, wr_addr_ff)) begin
      regs_ff[reg_index(wr_addr_ff)] <= wr_data_ff;
    end
  end

  logic [7:0] mode_sel;
  logic [7:0] slot_zero;
  logic [7:0] non_frame;
  logic [7:0] tx_mf_align;
  logic       transparent;

  assign mode_sel    = regs_ff[reg_index(ADDR_MODE_SELECT)];
  assign slot_zero   = regs_ff[reg_index(ADDR_SLOT_ZERO)];
  assign non_frame   = regs_ff[reg_index(ADDR_NON_FRAME)];
  assign tx_mf_align = regs_ff[reg_index(ADDR_TX_MF_ALIGN)];
  assign transparent = slot_zero[BIT_TX_TRANSPARENT];

  // Read data and drive enable, both registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= READ_UNMAPPED;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= rd_active;
      if (rd_active && hits_page(page_s2_ff, addr_s2_ff)) begin
        data_out <= regs_ff[reg_index(addr_s2_ff)];
      end else begin
        data_out <= READ_UNMAPPED;
      end
    end
  end

  // Mask words straight from their registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_0 <= REG_RESET;
      irq_mask_1 <= REG_RESET;
      irq_mask_2 <= REG_RESET;
      irq_mask_3 <= REG_RESET;
    end else begin
      irq_mask_0 <= regs_ff[reg_index(ADDR_IRQ_MASK_0)];
      irq_mask_1 <= regs_ff[reg_index(ADDR_IRQ_MASK_1)];
      irq_mask_2 <= regs_ff[reg_index(ADDR_IRQ_MASK_2)];
      irq_mask_3 <= regs_ff[reg_index(ADDR_IRQ_MASK_3)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AIS detector
  efm_ais_if ais_bus ();

  assign ais_bus.rx_bit        = rx_bit;
  assign ais_bus.rx_bit_valid  = rx_bit_valid;
  assign ais_bus.criterion_sel = mode_sel[BIT_AIS_CRITERION_SEL];

  efm_ais_det u_ais_det (
    .clk (clk),
    .rst (rst),
    .ais (ais_bus.det)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ais_detect <= 1'b0;
    end else begin
      ais_detect <= ais_bus.ais_found;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit overhead bit selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interworking_en <= 1'b0;
      tx_a_bit        <= 1'b0;
      tx_y_bit        <= 1'b1;
    end else begin
      interworking_en <= !mode_sel[BIT_INTERWORKING_DIS];
      if (mode_sel[BIT_REMOTE_ALARM_MAN]) begin
        tx_a_bit <= non_frame[BIT_MANUAL_ALARM];
      end else begin
        tx_a_bit <= basic_sync_ok;
      end
      if (mode_sel[BIT_YBIT_MANUAL]) begin
        tx_y_bit <= tx_mf_align[BIT_MANUAL_YBIT];
      end else begin
        tx_y_bit <= !mf_sync_ok;
      end
    end
  end

  // International bits only reach the line with CRC-4 sync off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc4_sync_en       <= 1'b1;
      intl_bits_from_reg <= 1'b0;
      intl_bit_fas       <= 1'b1;
      intl_bit_nfas      <= 1'b1;
    end else begin
      crc4_sync_en       <= !mode_sel[BIT_CRC4_SYNC_DISABLE];
      intl_bits_from_reg <= mode_sel[BIT_CRC4_SYNC_DISABLE];
      intl_bit_fas       <= slot_zero[BIT_INTL_FAS];
      intl_bit_nfas      <= slot_zero[BIT_INTL_NFAS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC-4 bits in slot zero during transparent transmit
  // Outside transparent mode the framer's own CRC is used, shown here as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_crc_bits <= 4'h0;
    end else if (!transparent) begin
      tx_crc_bits <= 4'h0;
    end else if (mode_sel[BIT_REMAINDER_MODIFY]) begin
      tx_crc_bits <= rx_crc_remainder ^ tx_change_crc;
    end else begin
      tx_crc_bits <= serial_tx_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reframe requests: sampled once per frame so a short pulse
  // shorter than a frame may be missed, which the host must avoid
  logic basic_prev_ff;
  logic mf_prev_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      basic_prev_ff       <= 1'b0;
      mf_prev_ff          <= 1'b0;
      basic_reframe_start <= 1'b0;
      mf_reframe_start    <= 1'b0;
    end else if (frame_start) begin
      basic_prev_ff       <= mode_sel[BIT_BASIC_REFRAME];
      mf_prev_ff          <= mode_sel[BIT_MF_REFRAME];
      basic_reframe_start <= basic_prev_ff && !mode_sel[BIT_BASIC_REFRAME];
      mf_reframe_start    <= mf_prev_ff && !mode_sel[BIT_MF_REFRAME];
    end else begin
      basic_reframe_start <= 1'b0;
      mf_reframe_start    <= 1'b0;
    end
  end
endmodule : efm_mode_ctrl

/* File: efm_line_model.sv */
// Framer-side stand-in: frame boundaries and a received line bit stream
module efm_line_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic quiet,
  output logic      frame_start,
  output logic      rx_bit,
  output logic      rx_bit_valid
);
  logic [7:0] pos_ff;
  // Bit position in a 256-bit frame, one valid bit per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_ff <= 8'h00;
    end else begin
      pos_ff <= pos_ff + 8'h01;
    end
  end
  // Quiet line sends all ones, otherwise a solid zero stream
  assign frame_start  = (pos_ff == 8'hFF);
  assign rx_bit_valid = !rst;
  assign rx_bit       = quiet;
endmodule // efm_line_model

/* File: efm_mode_ctrl_properties.sv */
module efm_mode_ctrl_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       frame_start,
  input wire logic       rx_bit_valid,
  input wire logic [3:0] serial_tx_input,
  input wire logic [3:0] rx_crc_remainder,
  input wire logic [3:0] tx_change_crc,
  input wire logic       ais_detect,
  input wire logic       crc4_sync_en,
  input wire logic       intl_bits_from_reg,
  input wire logic [3:0] tx_crc_bits,
  input wire logic       basic_reframe_start,
  input wire logic       mf_reframe_start,
  input wire logic [7:0] irq_mask_0
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Two sync flops plus the output register before the bus is driven
  sequence s_rd_low;
    (!cs_n && !rd_n && wr_n) [*3];
  endsequence
  read_answer_a: assert property (s_rd_low |=> data_oe)
    else $error("read not answered in time");
  idle_data_a: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data out not zero while idle");
  basic_edge_a: assert property (basic_reframe_start |-> $past(frame_start))
    else $error("basic reframe off a frame boundary");
  basic_pulse_a: assert property (basic_reframe_start |=> !basic_reframe_start)
    else $error("basic reframe pulse too long");
  mf_edge_a: assert property (mf_reframe_start |-> $past(frame_start))
    else $error("multiframe reframe off a frame boundary");
  mf_pulse_a: assert property (mf_reframe_start |=> !mf_reframe_start)
    else $error("multiframe reframe pulse too long");
  crc_pair_a: assert property (crc4_sync_en != intl_bits_from_reg)
    else $error("sync enable and bit source disagree");
  crc_source_a: assert property (tx_crc_bits == 4'h0 ||
      tx_crc_bits == $past(rx_crc_remainder ^ tx_change_crc) ||
      tx_crc_bits == $past(serial_tx_input))
    else $error("crc bits from no legal source");
  // Window end needs a valid bit, then detector flop and output flop follow
  ais_timing_a: assert property ($changed(ais_detect) |-> $past(rx_bit_valid, 2))
    else $error("alarm changed without line bits");
  // Strobe end: two sync flops, commit, then the mask output register
  mask_write_a: assert property ($changed(irq_mask_0) |->
      $past(cs_n || wr_n, 4) && !$past(cs_n || wr_n, 5))
    else $error("mask changed without a write");
endmodule // efm_mode_ctrl_properties
bind efm_mode_ctrl efm_mode_ctrl_properties u_props (.clk(clk), .rst(rst), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .data_out(data_out), .data_oe(data_oe),
  .frame_start(frame_start), .rx_bit_valid(rx_bit_valid), .serial_tx_input(serial_tx_input),
  .rx_crc_remainder(rx_crc_remainder), .tx_change_crc(tx_change_crc),
  .ais_detect(ais_detect), .crc4_sync_en(crc4_sync_en),
  .intl_bits_from_reg(intl_bits_from_reg), .tx_crc_bits(tx_crc_bits),
  .basic_reframe_start(basic_reframe_start), .mf_reframe_start(mf_reframe_start),
  .irq_mask_0(irq_mask_0));

/* File: efm_mode_ctrl_bench.sv */
module efm_mode_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import efm_pkg::*;
  typedef struct {
    logic [7:0] md, s0, nf, mf;
    logic       bs, ms;
    logic [6:0] e;
    logic [3:0] crc;
  } efm_row_t;
  logic       clk = 1'h0, rst = 1'h1, cs_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1;
  logic       quiet = 1'h0, bso = 1'h0, mso = 1'h0;
  logic [3:0] pg = 4'h1, ser = 4'h9, rxr = 4'h5, chg = 4'h3;
  logic [4:0] ad = 5'h00;
  logic [7:0] di = 8'h00, rv;
  wire  [7:0] dout, m0, m1, m2, m3;
  wire  [3:0] tcb;
  wire        oe, fs, rb, vb, ais, iw, cse, ta, ty, ifs, inf, ifr, brs, mrs;
  int         n_mismatch = 0, check_count = 0, nb = 0, nm = 0, nb0 = 0, nm0 = 0;
  // Mode, slot zero, alarm, Y source, sync inputs; {iw,cse,ifr,a,y,fas,nfas}, crc
  efm_row_t   rows [4] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 1'h1, 1'h1, 7'h68, 4'h0},
    '{8'h00, 8'h04, 8'h00, 8'h00, 1'h0, 1'h0, 7'h64, 4'h9},
    '{8'h7C, 8'h07, 8'h20, 8'h00, 1'h0, 1'h0, 7'h1B, 4'h6},
    '{8'h7C, 8'h05, 8'h00, 8'h04, 1'h1, 1'h1, 7'h16, 4'h6}};
  efm_mode_ctrl u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .page_sel(pg), .addr(ad), .data_in(di), .data_out(dout), .data_oe(oe),
    .frame_start(fs), .rx_bit(rb), .rx_bit_valid(vb), .basic_sync_ok(bso),
    .mf_sync_ok(mso), .serial_tx_input(ser), .rx_crc_remainder(rxr),
    .tx_change_crc(chg), .ais_detect(ais), .interworking_en(iw), .crc4_sync_en(cse),
    .tx_a_bit(ta), .tx_y_bit(ty), .intl_bit_fas(ifs), .intl_bit_nfas(inf),
    .intl_bits_from_reg(ifr), .tx_crc_bits(tcb), .basic_reframe_start(brs),
    .mf_reframe_start(mrs), .irq_mask_0(m0), .irq_mask_1(m1), .irq_mask_2(m2),
    .irq_mask_3(m3));
  efm_line_model u_line (.clk(clk), .rst(rst), .quiet(quiet), .frame_start(fs),
    .rx_bit(rb), .rx_bit_valid(vb));
  ////////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Count reframe pulses so a double start shows up; sampled away from the launch edge
  always @(negedge clk) begin
    nb += int'(brs === 1'h1);
    nm += int'(mrs === 1'h1);
  end
  task chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task note(input string s);
    $display("test %s done", s);
  endtask
  // Strobes held low four cycles, then high five: pins cross a two-flop synchroniser
  task wr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    pg = p; ad = a; di = d; cs_n = 1'h0; wr_n = 1'h0;
    cyc(4);
    cs_n = 1'h1; wr_n = 1'h1;
    cyc(5);
  endtask
  task rd(input logic [3:0] p, input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    pg = p; ad = a; cs_n = 1'h0; rd_n = 1'h0;
    cyc(4);
    d = dout;
    chk1(oe, 1'h1);
    cs_n = 1'h1; rd_n = 1'h1;
    cyc(5);
  endtask
  task finish_test;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Whole run is about 8k cycles; this allows nearly four times that
  initial begin
    #150000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    cyc(20);
    chk1(oe, 1'h0);
    chk1(ty, 1'h1);
    chk1(cse, 1'h1);
    chk1(ifs, 1'h1);
    rst = 1'h0;
    cyc(2);
    chk1(iw, 1'h1);
    note("reset");
    // Every word of the page: reset value, then write and read back
    for (int a = 16; a < 32; a++) begin
      rd(4'h1, 5'(a), rv);
      chk8(rv, REG_RESET);
      wr(4'h1, 5'(a), 8'hC0 | 8'(a));
      rd(4'h1, 5'(a), rv);
      chk8(rv, 8'hC0 | 8'(a));
    end
    chk8(m0, 8'hDB);
    chk8(m1, 8'hDC);
    chk8(m2, 8'hDD);
    chk8(m3, 8'hDE);
    wr(4'h2, ADDR_IRQ_MASK_0, 8'h00);
    chk8(m0, 8'hDB);
    rd(4'h1, 5'h05, rv);
    chk8(rv, READ_UNMAPPED);
    note("registers");
    foreach (rows[i]) begin
      bso = rows[i].bs;
      mso = rows[i].ms;
      wr(4'h1, ADDR_SLOT_ZERO, rows[i].s0);
      wr(4'h1, ADDR_NON_FRAME, rows[i].nf);
      wr(4'h1, ADDR_TX_MF_ALIGN, rows[i].mf);
      wr(4'h1, ADDR_MODE_SELECT, rows[i].md);
      cyc(2);
      chk8({1'h0, iw, cse, ifr, ta, ty, ifs, inf}, {1'h0, rows[i].e});
      chk8({4'h0, tcb}, {4'h0, rows[i].crc});
    end
    note("modes");
    // Reframe bits held for more than two frames, then cleared
    wr(4'h1, ADDR_MODE_SELECT, 8'h02);
    cyc(600);
    nb0 = nb;
    wr(4'h1, ADDR_MODE_SELECT, 8'h00);
    cyc(600);
    chk8(8'(nb - nb0), 8'h01);
    wr(4'h1, ADDR_MODE_SELECT, 8'h01);
    cyc(600);
    nm0 = nm;
    wr(4'h1, ADDR_MODE_SELECT, 8'h00);
    cyc(600);
    chk8(8'(nm - nm0), 8'h01);
    note("reframe");
    // Windows are not frame aligned, so limits allow for any phase
    cyc(1100);
    chk1(ais, 1'h0);
    quiet = 1'h1;
    cyc(505);
    chk1(ais, 1'h0);
    cyc(525);
    chk1(ais, 1'h1);
    quiet = 1'h0;
    cyc(1100);
    chk1(ais, 1'h0);
    wr(4'h1, ADDR_MODE_SELECT, 8'h80);
    quiet = 1'h1;
    cyc(1015);
    chk1(ais, 1'h0);
    cyc(530);
    chk1(ais, 1'h1);
    note("ais");
    finish_test;
  end
endmodule // efm_mode_ctrl_bench
